/* File: logic/pps_defs.svh */
// Constants for the palette pixel serializer
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
// Port target select codes
`define PPS_SEL_PTR 2'h0
`define PPS_SEL_LUT 2'h1
`define PPS_SEL_CTRL 2'h2
`define PPS_SEL_OVL 2'h3
// Control register indices seen through the pointer
`define PPS_REG_RMASK 8'h04
`define PPS_REG_BMASK 8'h05
`define PPS_REG_CMD 8'h06
`define PPS_REG_TEST 8'h07
// Reset values
`define PPS_RMASK_RST 8'hff
`define PPS_BMASK_RST 8'h00
`define PPS_CMD_RST 8'h00
`define PPS_TEST_RST 8'h00
`define PPS_PTR_RST 8'h00
// Command register fields
`define PPS_CMD_OVL 0
`define PPS_CMD_BLINK 1
`define PPS_CMD_RATE_LO 2
`define PPS_CMD_RATE_HI 3
// Colour byte counter values
`define PPS_BYTE_RED 2'h0
`define PPS_BYTE_GREEN 2'h1
`define PPS_BYTE_BLUE 2'h2
// Lane layout
`define PPS_LANES 4
`define PPS_LAST_LANE 2'h3
`define PPS_OVL_NONE 2'h0
// Timing
`define PPS_CLK_MHZ 100
`define PPS_LOAD_PERIOD_NS 43
`define PPS_DOT_MHZ_X10K 929405
`define PPS_BLINK_BASE_MS 16
`define PPS_BLINK_CYCLES (`PPS_BLINK_BASE_MS * 1000 * `PPS_CLK_MHZ)
`endif

/* File: logic/pps_fifo.sv */
// Small valid/ready buffer for load words
`timescale 1ns/1ps
module pps_fifo #(
    parameter int W = 40,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] ent_q [0:DEPTH-1];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = ent_q[rp_q];

    always_ff @(posedge clock) begin
        if (ce && push) begin
            ent_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (push) begin
                wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

/* File: logic/pps_lut_mem.sv */
// Dual-port colour table memory with registered read data
`timescale 1ns/1ps
module pps_lut_mem #(
    parameter int AW = 8,
    parameter int DW = 24
) (
    // Clock
    input wire logic clock,
    input wire logic ce,
    // Processor port
    input wire logic a_we,
    input wire logic a_re,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_wdata,
    output logic [DW-1:0] a_rdata,
    // Pixel port
    input wire logic b_re,
    input wire logic [AW-1:0] b_addr,
    output logic [DW-1:0] b_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock) begin
        if (ce && a_we) begin
            mem[a_addr] <= a_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (ce && a_re) begin
            a_rdata <= mem[a_addr];
        end
    end

    // Read data holds while the pixel pipe is stalled
    always_ff @(posedge clock) begin
        if (ce && b_re) begin
            b_rdata <= mem[b_addr];
        end
    end
endmodule

/* File: logic/pps_pkg.sv */
// Types shared by the palette pixel serializer files
package pps_pkg;
    typedef struct packed {
        logic [7:0] d;
        logic [7:0] c;
        logic [7:0] b;
        logic [7:0] a;
    } pps_quad_t;
    typedef struct packed {
        logic [7:0] ovl;
        pps_quad_t pix;
    } pps_load_t;
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } pps_rgb_t;
    typedef enum logic [2:0] {
        PPS_IDLE = 3'b001,
        PPS_FETCH = 3'b010,
        PPS_ANSWER = 3'b100
    } pps_cpu_state_t;
endpackage

/* File: logic/pps_top.sv */
// Palette pixel serializer: load capture, serial readout, colour lookup, processor port
`timescale 1ns/1ps
`include "pps_defs.svh"
module pps_top
    import pps_pkg::*;
#(
    parameter int BLINK_CYCLES = `PPS_BLINK_CYCLES,
    parameter int DEPTH = 2
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Pixel pins
    input wire logic pixel_load_clock,
    input wire logic [7:0] pixel_lane_a,
    input wire logic [7:0] pixel_lane_b,
    input wire logic [7:0] pixel_lane_c,
    input wire logic [7:0] pixel_lane_d,
    input wire logic [7:0] pixel_lane_e_unused,
    input wire logic [7:0] overlay_lanes,
    // Load flow status
    output logic load_ready,
    output logic load_overrun,
    // Dot rate enable
    input wire logic dot_clock,
    // Colour stream to converters
    output logic colour_valid,
    input wire logic colour_ready,
    output pps_rgb_t colour_out,
    // Processor port
    input wire logic [1:0] port_target_select,
    input wire logic cpu_write,
    input wire logic cpu_read,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_ready,
    output logic cpu_ack,
    output logic [7:0] cpu_rdata
);
    localparam int SW = 41;
    localparam int LDB = 40;

    logic [SW-1:0] pin_raw;
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic [SW-1:0] s3_q;
    logic [SW-1:0] filt_q;
    logic ld_prev_q;
    logic load_edge;
    pps_load_t load_word;
    logic buf_valid;
    logic buf_ready;
    pps_load_t buf_data;
    pps_load_t word_q;
    logic have_q;
    logic [1:0] pix_cnt_q;
    logic [7:0] cur_pix;
    logic [1:0] cur_code;
    logic [7:0] idx;
    logic issue;
    logic s1_valid_q;
    logic s1_ovl_q;
    logic [1:0] s1_code_q;
    logic out_load;
    logic colour_valid_q;
    pps_rgb_t colour_q;
    pps_rgb_t lut_b_rdata;
    pps_rgb_t lut_a_rdata;
    pps_rgb_t ovl_q [0:3];
    logic [7:0] ptr_q;
    logic [7:0] rmask_q;
    logic [7:0] bmask_q;
    logic [7:0] cmd_q;
    logic [7:0] test_q;
    logic [1:0] byte_q;
    logic [7:0] red_q;
    logic [7:0] green_q;
    logic [31:0] blink_cnt_q;
    logic [31:0] blink_period;
    logic blink_off_q;
    pps_cpu_state_t st_q;
    logic [1:0] sel_q;
    logic wr_q;
    logic [7:0] wdata_q;
    logic colour_sel;
    logic blue_end;
    logic lut_we;
    pps_rgb_t commit_rgb;
    logic [7:0] rd_byte;

    // Pin synchroniser; fifth lane never enters the design
    assign pin_raw = {pixel_load_clock, overlay_lanes, pixel_lane_d, pixel_lane_c,
                      pixel_lane_b, pixel_lane_a};

    // A level is taken only once two later stages agree, filtering one-sample glitches
    for (genvar gi = 0; gi < SW; gi++) begin : g_sync
        always_ff @(posedge clock) begin
            if (rst) begin
                s1_q[gi] <= 1'b0;
                s2_q[gi] <= 1'b0;
                s3_q[gi] <= 1'b0;
                filt_q[gi] <= 1'b0;
            end else if (ce) begin
                s1_q[gi] <= pin_raw[gi];
                s2_q[gi] <= s1_q[gi];
                s3_q[gi] <= s2_q[gi];
                if (s2_q[gi] == s3_q[gi]) begin
                    filt_q[gi] <= s3_q[gi];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ld_prev_q <= 1'b0;
        end else if (ce) begin
            ld_prev_q <= filt_q[LDB];
        end
    end

    // Lanes share the load clock's delay, so they are aligned at the edge
    assign load_edge = filt_q[LDB] & ~ld_prev_q;
    assign load_word = pps_load_t'(filt_q[LDB-1:0]);
    assign load_ready = buf_ready;
    assign load_overrun = ce & load_edge & ~buf_ready;

    pps_fifo #(
        .W($bits(pps_load_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .in_valid(load_edge),
        .in_ready(buf_ready),
        .in_data(load_word),
        .out_valid(buf_valid),
        .out_ready(~have_q | (issue & (pix_cnt_q == `PPS_LAST_LANE))),
        .out_data(buf_data)
    );

    // Serial readout of the held word
    always_comb begin
        unique case (pix_cnt_q)
            2'h0: cur_pix = word_q.pix.a;
            2'h1: cur_pix = word_q.pix.b;
            2'h2: cur_pix = word_q.pix.c;
            2'h3: cur_pix = word_q.pix.d;
        endcase
    end
    assign cur_code = word_q.ovl[{pix_cnt_q, 1'b0} +: 2];

    assign out_load = s1_valid_q & (~colour_valid_q | colour_ready);
    assign issue = dot_clock & have_q & (~s1_valid_q | out_load);

    always_ff @(posedge clock) begin
        if (rst) begin
            have_q <= 1'b0;
            pix_cnt_q <= 2'h0;
        end else if (ce) begin
            if (issue) begin
                pix_cnt_q <= pix_cnt_q + 2'h1;
                if (pix_cnt_q == `PPS_LAST_LANE) begin
                    have_q <= 1'b0;
                end
            end
            if (buf_valid && (~have_q || (issue && pix_cnt_q == `PPS_LAST_LANE))) begin
                have_q <= 1'b1;
                pix_cnt_q <= 2'h0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (ce && buf_valid && (~have_q || (issue && pix_cnt_q == `PPS_LAST_LANE))) begin
            word_q <= buf_data;
        end
    end

    // Plane masking and blink gating of the index
    always_comb begin
        idx = cur_pix & rmask_q;
        if (cmd_q[`PPS_CMD_BLINK] && blink_off_q) begin
            idx = idx & ~bmask_q;
        end
    end

    // Blink rate is base period times a power of two from the command register
    assign blink_period = 32'(BLINK_CYCLES) << cmd_q[`PPS_CMD_RATE_HI:`PPS_CMD_RATE_LO];

    always_ff @(posedge clock) begin
        if (rst) begin
            blink_cnt_q <= 32'h0;
            blink_off_q <= 1'b0;
        end else if (ce) begin
            if (blink_cnt_q >= blink_period - 32'h1) begin
                blink_cnt_q <= 32'h0;
                blink_off_q <= ~blink_off_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h1;
            end
        end
    end

    // Lookup stage
    always_ff @(posedge clock) begin
        if (rst) begin
            s1_valid_q <= 1'b0;
            s1_ovl_q <= 1'b0;
            s1_code_q <= 2'h0;
        end else if (ce) begin
            if (issue) begin
                s1_valid_q <= 1'b1;
                s1_ovl_q <= cmd_q[`PPS_CMD_OVL] & (cur_code != `PPS_OVL_NONE);
                s1_code_q <= cur_code;
            end else if (out_load) begin
                s1_valid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            colour_valid_q <= 1'b0;
            colour_q <= '0;
        end else if (ce) begin
            if (out_load) begin
                colour_valid_q <= 1'b1;
                colour_q <= s1_ovl_q ? ovl_q[s1_code_q] : lut_b_rdata;
            end else if (colour_ready) begin
                colour_valid_q <= 1'b0;
            end
        end
    end

    assign colour_valid = colour_valid_q;
    assign colour_out = colour_q;

    // Table memory, processor on one port and pixel path on the other
    pps_lut_mem #(
        .AW(8),
        .DW($bits(pps_rgb_t))
    ) u_lut (
        .clock(clock),
        .ce(ce),
        .a_we(lut_we),
        .a_re(st_q == PPS_IDLE),
        .a_addr(ptr_q),
        .a_wdata(commit_rgb),
        .a_rdata(lut_a_rdata),
        .b_re(issue),
        .b_addr(idx),
        .b_rdata(lut_b_rdata)
    );

    // Processor port sequencing
    assign cpu_ready = (st_q == PPS_IDLE);
    assign cpu_ack = (st_q == PPS_ANSWER);
    assign colour_sel = sel_q[0];
    assign blue_end = (st_q == PPS_FETCH) & colour_sel & (byte_q == `PPS_BYTE_BLUE);
    assign commit_rgb = '{r: red_q, g: green_q, b: wdata_q};
    assign lut_we = blue_end & wr_q & (sel_q == `PPS_SEL_LUT);

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= PPS_IDLE;
            sel_q <= `PPS_SEL_PTR;
            wr_q <= 1'b0;
            wdata_q <= 8'h00;
        end else if (ce) begin
            unique case (st_q)
                PPS_IDLE: begin
                    if (cpu_write || cpu_read) begin
                        st_q <= PPS_FETCH;
                        sel_q <= port_target_select;
                        wr_q <= cpu_write;
                        wdata_q <= cpu_wdata;
                    end
                end
                PPS_FETCH: st_q <= PPS_ANSWER;
                PPS_ANSWER: st_q <= PPS_IDLE;
            endcase
        end
    end

    // Colour byte counter and pointer
    always_ff @(posedge clock) begin
        if (rst) begin
            byte_q <= `PPS_BYTE_RED;
            ptr_q <= `PPS_PTR_RST;
        end else if (ce && st_q == PPS_FETCH) begin
            if (!colour_sel) begin
                byte_q <= `PPS_BYTE_RED;
                if (wr_q && sel_q == `PPS_SEL_PTR) begin
                    ptr_q <= wdata_q;
                end
            end else if (byte_q == `PPS_BYTE_BLUE) begin
                byte_q <= `PPS_BYTE_RED;
                ptr_q <= ptr_q + 8'h01;
            end else begin
                byte_q <= byte_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (ce && st_q == PPS_FETCH && wr_q && colour_sel) begin
            if (byte_q == `PPS_BYTE_RED) begin
                red_q <= wdata_q;
            end
            if (byte_q == `PPS_BYTE_GREEN) begin
                green_q <= wdata_q;
            end
        end
    end

    // Overlay colours, indexed by the pointer's low bits
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < `PPS_LANES; i++) begin
                ovl_q[i] <= '0;
            end
        end else if (ce && blue_end && wr_q && sel_q == `PPS_SEL_OVL) begin
            ovl_q[ptr_q[1:0]] <= commit_rgb;
        end
    end

    // Control registers
    always_ff @(posedge clock) begin
        if (rst) begin
            rmask_q <= `PPS_RMASK_RST;
            bmask_q <= `PPS_BMASK_RST;
            cmd_q <= `PPS_CMD_RST;
            test_q <= `PPS_TEST_RST;
        end else if (ce && st_q == PPS_FETCH && wr_q && sel_q == `PPS_SEL_CTRL) begin
            unique case (ptr_q)
                `PPS_REG_RMASK: rmask_q <= wdata_q;
                `PPS_REG_BMASK: bmask_q <= wdata_q;
                `PPS_REG_CMD: cmd_q <= wdata_q;
                `PPS_REG_TEST: test_q <= wdata_q;
                default: ;
            endcase
        end
    end

    // Read data byte selection
    function automatic logic [7:0] pick(input pps_rgb_t c, input logic [1:0] b);
        logic [7:0] v;
        v = c.r;
        if (b == `PPS_BYTE_GREEN) begin
            v = c.g;
        end
        if (b == `PPS_BYTE_BLUE) begin
            v = c.b;
        end
        return v;
    endfunction

    always_comb begin
        rd_byte = 8'h00;
        unique case (sel_q)
            `PPS_SEL_PTR: rd_byte = ptr_q;
            `PPS_SEL_LUT: rd_byte = pick(lut_a_rdata, byte_q);
            `PPS_SEL_OVL: rd_byte = pick(ovl_q[ptr_q[1:0]], byte_q);
            `PPS_SEL_CTRL: begin
                if (ptr_q == `PPS_REG_RMASK) begin
                    rd_byte = rmask_q;
                end else if (ptr_q == `PPS_REG_BMASK) begin
                    rd_byte = bmask_q;
                end else if (ptr_q == `PPS_REG_CMD) begin
                    rd_byte = cmd_q;
                end else if (ptr_q == `PPS_REG_TEST) begin
                    rd_byte = test_q;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cpu_rdata <= 8'h00;
        end else if (ce && st_q == PPS_FETCH && !wr_q) begin
            cpu_rdata <= rd_byte;
        end
    end
endmodule

/* File: tb/pps_checker.sv */
// Port assertions for the palette pixel serializer
`timescale 1ns/1ps
module pps_checker
    import pps_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Processor port
    input wire logic cpu_write,
    input wire logic cpu_read,
    input wire logic cpu_ready,
    input wire logic cpu_ack,
    input wire logic [7:0] cpu_rdata,
    // Streams
    input wire logic load_ready,
    input wire logic load_overrun,
    input wire logic colour_valid,
    input wire logic colour_ready,
    input wire pps_rgb_t colour_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic take;
    assign take = ce && cpu_ready && (cpu_write || cpu_read);
    sequence s_fetch;
        !cpu_ready && !cpu_ack;
    endsequence
    sequence s_answer;
        cpu_ack && !cpu_ready;
    endsequence
    a_ack_timing: assert property (take |=> s_fetch ##1 s_answer)
        else $error("answer not two cycles after request");
    a_ack_pulse: assert property (cpu_ack |=> !cpu_ack && cpu_ready)
        else $error("answer longer than one cycle");
    a_ack_cause: assert property ($rose(cpu_ack) |-> $past(take, 2))
        else $error("answer without request");
    a_rdata_hold: assert property (!$stable(cpu_rdata) |-> cpu_ack)
        else $error("read data moved outside an answer");
    a_colour_hold: assert property (colour_valid && !colour_ready |=> colour_valid && $stable(colour_out))
        else $error("stalled colour changed");
    a_valid_drop: assert property ($fell(colour_valid) |-> $past(colour_ready))
        else $error("colour dropped before acceptance");
    a_overrun_full: assert property (load_overrun |-> !load_ready)
        else $error("overrun with room in buffer");
    a_overrun_once: assert property (load_overrun |=> !load_overrun [*8])
        else $error("one load edge counted twice");
    cover property (take ##2 cpu_ack);
endmodule
bind pps_top pps_checker i_chk (.clock, .rst, .ce, .cpu_write, .cpu_read, .cpu_ready, .cpu_ack, .cpu_rdata,
    .load_ready, .load_overrun, .colour_valid, .colour_ready, .colour_out);

/* File: tb/pps_mem_model.sv */
// Video memory side model: load clock and pixel lanes
`timescale 1ns/1ps
module pps_mem_model (
    // Load clock
    output logic pixel_load_clock,
    // Pixel lanes
    output logic [7:0] lane_a,
    output logic [7:0] lane_b,
    output logic [7:0] lane_c,
    output logic [7:0] lane_d,
    output logic [7:0] lane_e,
    output logic [7:0] ovl
);
    initial begin
        pixel_load_clock = 1'b0;
        {lane_d, lane_c, lane_b, lane_a} = 32'h0;
        lane_e = 8'h00;
        ovl = 8'h00;
    end
    // Load clock stands still between frames; gap slows the partner down
    task automatic send(input int n, input logic [7:0] base, input int gap, input logic [7:0] code);
        for (int w = 0; w < n; w++) begin
            ovl = code;
            lane_a = base + 8'(4 * w);
            lane_b = lane_a + 8'h01;
            lane_c = lane_a + 8'h02;
            lane_d = lane_a + 8'h03;
            #62.5 pixel_load_clock = 1'b1;
            #62.5 pixel_load_clock = 1'b0;
            #(gap);
        end
        // Released lanes must not look like a held pixel
        {ovl, lane_d, lane_c, lane_b, lane_a} = ~{ovl, lane_d, lane_c, lane_b, lane_a};
    endtask
endmodule

/* File: tb/test_palette_pixel_serializer.sv */
// Self-checking bench for the palette pixel serializer
`timescale 1ns/1ps
`include "pps_defs.svh"
module test_palette_pixel_serializer
    import pps_pkg::*;
;
    logic clock, rst, ce, dot_clock, dot_half, colour_ready, cpu_write, cpu_read, seen_full;
    logic pixel_load_clock, load_ready, load_overrun, colour_valid, cpu_ready, cpu_ack;
    logic [1:0] port_target_select;
    logic [7:0] cpu_wdata, cpu_rdata, lane_a, lane_b, lane_c, lane_d, lane_e, ovl;
    pps_rgb_t colour_out;
    pps_rgb_t got_q[$];
    int gap_q[$];
    int errors, total_checks, overruns, cyc, last_cyc;

    pps_top #(.BLINK_CYCLES(16), .DEPTH(2)) i_dut (.clock(clock), .rst(rst), .ce(ce),
        .pixel_load_clock(pixel_load_clock), .pixel_lane_a(lane_a), .pixel_lane_b(lane_b),
        .pixel_lane_c(lane_c), .pixel_lane_d(lane_d), .pixel_lane_e_unused(lane_e), .overlay_lanes(ovl),
        .load_ready(load_ready), .load_overrun(load_overrun), .dot_clock(dot_clock),
        .colour_valid(colour_valid), .colour_ready(colour_ready), .colour_out(colour_out),
        .port_target_select(port_target_select), .cpu_write(cpu_write), .cpu_read(cpu_read),
        .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata));
    pps_mem_model i_mem (.pixel_load_clock(pixel_load_clock), .lane_a(lane_a), .lane_b(lane_b),
        .lane_c(lane_c), .lane_d(lane_d), .lane_e(lane_e), .ovl(ovl));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        dot_clock <= dot_half ? ~dot_clock : 1'b1;
    end
    // Sampled mid-cycle so design updates have landed
    always @(negedge clock) begin
        if (!rst && colour_valid === 1'b1 && colour_ready === 1'b1) begin
            got_q.push_back(colour_out);
            gap_q.push_back(cyc - last_cyc);
            last_cyc = cyc;
        end
        if (load_overrun === 1'b1) overruns++;
        if (load_ready === 1'b0) seen_full = 1'b1;
    end

    function automatic logic [23:0] col(input logic [7:0] i);
        return {i, ~i, i ^ 8'h3c};
    endfunction
    task automatic end_sim();
        $display("Checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic hang(input string msg);
        errors++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
        end_sim();
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic cpu(input logic wr, input logic [1:0] sel, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge clock);
        port_target_select <= sel;
        cpu_write <= wr;
        cpu_read <= ~wr;
        cpu_wdata <= wd;
        n = 0;
        @(posedge clock);
        cpu_write <= 1'b0;
        cpu_read <= 1'b0;
        while (cpu_ack !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 6) hang("no processor answer");
        end
        rd = cpu_rdata;
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        logic [7:0] x;
        cpu(1'b1, sel, d, x);
    endtask
    task automatic rd(input logic [1:0] sel, output logic [7:0] v);
        cpu(1'b0, sel, 8'h00, v);
    endtask
    task automatic write3(input logic [1:0] sel, input logic [23:0] c);
        wr(sel, c[23:16]);
        wr(sel, c[15:8]);
        wr(sel, c[7:0]);
    endtask
    task automatic read3(input logic [1:0] sel, output logic [23:0] c);
        rd(sel, c[23:16]);
        rd(sel, c[15:8]);
        rd(sel, c[7:0]);
    endtask
    task automatic wait_n(input int n);
        int k;
        k = 0;
        while (got_q.size() < n) begin
            @(posedge clock);
            k++;
            if (k > 3000) hang("colour stream stalled");
        end
    endtask

    task automatic s_regs();
        logic [7:0] v;
        logic [7:0] exp_rst[4] = '{8'hff, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 5; k++) begin
            wr(`PPS_SEL_PTR, 8'h04 + 8'(k));
            if (k == 4) wr(`PPS_SEL_CTRL, 8'h55);
            rd(`PPS_SEL_CTRL, v);
            check(v, k < 4 ? exp_rst[k] : 8'h00, "control register");
            rd(`PPS_SEL_PTR, v);
            check(v, 8'h04 + 8'(k), "pointer kept by control access");
        end
    endtask
    task automatic s_table();
        logic [7:0] v;
        logic [23:0] c;
        wr(`PPS_SEL_PTR, 8'h00);
        for (int i = 0; i < 64; i++) write3(`PPS_SEL_LUT, col(8'(i)));
        wr(`PPS_SEL_PTR, 8'hff);
        write3(`PPS_SEL_LUT, col(8'hff));
        rd(`PPS_SEL_PTR, v);
        check(v, 8'h00, "pointer wrap after blue");
        read3(`PPS_SEL_LUT, c);
        check(c, col(8'h00), "entry 00");
        read3(`PPS_SEL_LUT, c);
        check(c, col(8'h01), "entry after step");
        wr(`PPS_SEL_PTR, 8'hff);
        read3(`PPS_SEL_LUT, c);
        check(c, col(8'hff), "entry ff");
    endtask
    task automatic s_overlay();
        logic [7:0] v;
        logic [23:0] c;
        wr(`PPS_SEL_PTR, 8'h02);
        write3(`PPS_SEL_OVL, 24'h123456);
        rd(`PPS_SEL_PTR, v);
        check(v, 8'h03, "pointer after overlay write");
        wr(`PPS_SEL_PTR, 8'h02);
        read3(`PPS_SEL_OVL, c);
        check(c, 24'h123456, "overlay colour");
    endtask
    task automatic s_stream();
        for (int m = 0; m < 2; m++) begin
            @(posedge clock);
            dot_half <= m[0];
            got_q.delete();
            gap_q.delete();
            i_mem.send(2, 8'h08, 8 * m, 8'h00);
            wait_n(8);
            for (int k = 0; k < 8; k++) begin
                check(got_q[k], col(8'h08 + 8'(k)), "pixel colour in lane order");
                if (k % 4 != 0) check(gap_q[k], 1 + m, "pixel spacing");
            end
        end
    endtask
    task automatic s_stall();
        int e;
        @(posedge clock);
        colour_ready <= 1'b0;
        dot_half <= 1'b0;
        overruns = 0;
        seen_full = 1'b0;
        got_q.delete();
        i_mem.send(6, 8'h10, 40, 8'h00);
        check(seen_full, 1'b1, "buffer refused when full");
        // One word held by the serializer, two in the buffer, the rest are lost
        check(overruns, 6 - 1 - 2, "lost words reported");
        @(posedge clock);
        colour_ready <= 1'b1;
        wait_n(24 - 4 * overruns);
        repeat (50) @(posedge clock);
        check(got_q.size(), 24 - 4 * overruns, "colours after drain");
        e = 16;
        foreach (got_q[k]) begin
            while (e < 40 && got_q[k] !== col(8'(e))) e++;
            check(e < 40, 1'b1, "drained colours in order");
            e++;
        end
    endtask
    task automatic s_modes();
        logic [7:0] v;
        logic [23:0] exp_c[4];
        exp_c = '{col(8'h08), col(8'h09), 24'h123456, col(8'h0b)};
        wr(`PPS_SEL_PTR, `PPS_REG_RMASK);
        wr(`PPS_SEL_CTRL, 8'h0f);
        wr(`PPS_SEL_PTR, `PPS_REG_CMD);
        wr(`PPS_SEL_CTRL, 8'h01);
        rd(`PPS_SEL_CTRL, v);
        check(v, 8'h01, "command register written");
        got_q.delete();
        // Lane c carries overlay code 2, the others none
        i_mem.send(1, 8'h18, 0, 8'h20);
        wait_n(4);
        for (int k = 0; k < 4; k++) check(got_q[k], exp_c[k], "masked index and overlay colour");
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        dot_half = 1'b0;
        dot_clock = 1'b0;
        colour_ready = 1'b1;
        cpu_write = 1'b0;
        cpu_read = 1'b0;
        cpu_wdata = 8'h00;
        port_target_select = 2'h0;
        {errors, total_checks, overruns, cyc, last_cyc} = '0;
        seen_full = 1'b0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        s_regs();
        s_table();
        s_overlay();
        s_stream();
        s_stall();
        s_modes();
        end_sim();
    end
endmodule
